//--- verification/acs_monitor.sv
// Port checker for the conversion sequencer
`default_nettype none
module acs_monitor (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic SLEEP,
    input wire logic [5:0] CHANNEL_SELECT,
    input wire logic CHANNEL_VALID,
    input wire logic CONV_POWER,
    input wire logic CONVERSION_DONE_FLAG,
    input wire logic WAKE_REQ
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);
    logic req;
    logic stat_dp_ff;
    logic clr_ff;
    logic [5:0] ch;
    assign req = HSEL && HTRANS[1] && HREADY;
    assign ch = CHANNEL_SELECT;
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            stat_dp_ff <= 1'b0;
            clr_ff <= 1'b0;
        end else begin
            stat_dp_ff <= req && HWRITE && HADDR[7:0] == acs_pkg::OFS_STAT;
            clr_ff <= stat_dp_ff && HWDATA[0];
        end
    end
    sequence rd_s;
        req && !HWRITE;
    endsequence
    sequence clr_s;
        req && HWRITE && HADDR[7:0] == acs_pkg::OFS_STAT ##1 HWDATA[0];
    endsequence
    chk_resp_okay: assert property (HRESP == 1'b0)
        else $error("error response");
    chk_ready_up: assert property (RESETN [*3] |-> HREADYOUT)
        else $error("ready low after reset");
    chk_rdata_upper: assert property (rd_s |=> HRDATA[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_rdata_unmapped: assert property (rd_s and HADDR[7:0] > acs_pkg::OFS_INTEN
        |=> HRDATA == 32'h0) else $error("unmapped read not zero");
    chk_flag_clear: assert property (clr_s |=> !CONVERSION_DONE_FLAG)
        else $error("flag not cleared");
    chk_flag_sticky: assert property ($fell(CONVERSION_DONE_FLAG) |-> clr_ff)
        else $error("flag dropped by itself");
    chk_wake_pulse: assert property (WAKE_REQ |=> !WAKE_REQ)
        else $error("wake longer than one cycle");
    chk_wake_cause: assert property (WAKE_REQ |-> SLEEP ##[0:2] CONVERSION_DONE_FLAG)
        else $error("wake without completion in sleep");
    chk_power_awake: assert property ($rose(CONV_POWER) |-> !SLEEP)
        else $error("powered up in sleep");
    chk_chan_valid: assert property (HREADYOUT && $past(HREADYOUT) && $stable(ch)
        |-> CHANNEL_VALID == (ch <= 6'h05 || (ch >= 6'h0C && ch <= 6'h2F) || ch >= 6'h3B))
        else $error("channel valid wrong");
endmodule : acs_monitor
bind acs_sequencer acs_monitor i_mon (.MCLK(MCLK), .RESETN(RESETN), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SLEEP(SLEEP),
    .CHANNEL_SELECT(CHANNEL_SELECT), .CHANNEL_VALID(CHANNEL_VALID),
    .CONV_POWER(CONV_POWER), .CONVERSION_DONE_FLAG(CONVERSION_DONE_FLAG),
    .WAKE_REQ(WAKE_REQ));
`default_nettype wire

//--- verification/acs_partner.sv
// Comparator model for the analog input against the trial code
`default_nettype none
module acs_partner (
    input wire logic clk,
    input wire logic slow,
    input wire logic [9:0] dac_code,
    input wire logic [9:0] vin,
    output logic comp
);
    timeunit 1ns;
    timeprecision 100ps;
    logic comp_ff = 1'b0;
    // Slow mode lags the trial code by one cycle
    always_ff @(posedge clk) begin
        comp_ff <= vin >= dac_code;
    end
    assign comp = slow ? comp_ff : (vin >= dac_code);
endmodule : acs_partner
`default_nettype wire

//--- verification/test_acs_sequencer.sv
// Self-checking bench for the conversion sequencer
`default_nettype none
module test_acs_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    logic MCLK = 1'b0;
    logic RESETN = 1'b0;
    logic HSEL = 1'b0, HWRITE = 1'b0, SLEEP = 1'b0, slow = 1'b0, rd_dp = 1'b0;
    logic [1:0] HTRANS = 2'h0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
    logic [17:0] TRIG_SOURCES = 18'h0;
    logic [9:0] vin = 10'h0;
    wire logic [31:0] HRDATA;
    wire logic [9:0] DAC_CODE;
    wire logic [5:0] CHANNEL_SELECT;
    wire logic HREADYOUT, COMP_IN, CHANNEL_VALID, CONV_POWER, CONVERSION_DONE_FLAG, WAKE_REQ;
    int error_cnt = 0, n_checks = 0, wakes = 0;
    logic [31:0] exp_q[$];
    acs_sequencer i_dut (.MCLK(MCLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(),
        .TRIG_SOURCES(TRIG_SOURCES), .SLEEP(SLEEP), .COMP_IN(COMP_IN), .DAC_CODE(DAC_CODE),
        .CHANNEL_SELECT(CHANNEL_SELECT), .CHANNEL_VALID(CHANNEL_VALID),
        .CONV_POWER(CONV_POWER), .CONVERSION_DONE_FLAG(CONVERSION_DONE_FLAG),
        .WAKE_REQ(WAKE_REQ));
    acs_partner i_cmp (.clk(MCLK), .slow(slow), .dac_code(DAC_CODE), .vin(vin),
        .comp(COMP_IN));
    initial begin
        forever #2 MCLK = ~MCLK;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic pin(input logic got, input logic exp);
        cmp({31'h0, got}, {31'h0, exp});
    endtask : pin
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic wait_flag(input int n);
        repeat (n) begin
            @(posedge MCLK);
            if (CONVERSION_DONE_FLAG === 1'b1) return;
        end
    endtask : wait_flag
    task automatic do_reset();
        RESETN <= 1'b0;
        repeat (20) @(posedge MCLK);
        RESETN <= 1'b1;
        repeat (3) @(posedge MCLK);
    endtask : do_reset
    // Read data is taken at the edge that ends the data phase
    always @(posedge MCLK) begin
        if (rd_dp && HREADYOUT === 1'b1) begin
            cmp(HRDATA, exp_q.pop_front());
        end
        if (HREADYOUT === 1'b1) begin
            rd_dp <= HSEL && HTRANS[1] && !HWRITE;
        end
        if (WAKE_REQ === 1'b1) begin
            wakes++;
        end
    end
    initial begin
        #200us;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        logic [5:0] ch;
        logic [31:0] c0;
        void'($urandom(32'h7a15ef97));
        do_reset();
        for (int a = 0; a < 32; a += 4) begin
            rd(8'(a), 32'h0);
        end
        pin(CONV_POWER, 1'b0);
        wr(acs_pkg::OFS_CTRL0, 32'h3);
        rd(acs_pkg::OFS_CTRL0, 32'h1);
        pin(CONV_POWER, 1'b1);
        for (int i = 0; i < 4; i++) begin
            ch = (i == 0) ? 6'h3B : 6'($urandom);
            vin <= 10'($urandom % 1023);
            slow <= i[0];
            c0 = {24'h0, ch, 2'b01};
            wr(acs_pkg::OFS_CTRL1, {24'h0, i[1], 3'(i % 3), 4'h0});
            wr(acs_pkg::OFS_CTRL0, c0);
            wr(acs_pkg::OFS_CTRL0, c0 | 32'h2);
            rd(acs_pkg::OFS_CTRL0, c0 | 32'h2);
            wait_flag(200);
            repeat (2) @(posedge MCLK);
            rd(acs_pkg::OFS_CTRL0, c0);
            rd(acs_pkg::OFS_STAT, 32'h1);
            rd(acs_pkg::OFS_RES_HI, i[1] ? 32'(vin[9:2]) : 32'(vin[9:8]));
            rd(acs_pkg::OFS_RES_LO, i[1] ? 32'({vin[1:0], 6'h0}) : 32'(vin[7:0]));
            wr(acs_pkg::OFS_STAT, 32'h1);
            rd(acs_pkg::OFS_STAT, 32'h0);
            cmp(32'(CHANNEL_SELECT), 32'(ch));
            pin(CHANNEL_VALID, ch <= 6'h05 || (ch >= 6'h0C && ch <= 6'h2F) || ch >= 6'h3B);
        end
        vin <= 10'h380;
        wr(acs_pkg::OFS_CTRL1, 32'h20);
        wr(acs_pkg::OFS_CTRL0, c0 | 32'h2);
        repeat (26) @(posedge MCLK);
        wr(acs_pkg::OFS_CTRL0, c0);
        repeat (3) @(posedge MCLK);
        rd(acs_pkg::OFS_RES_HI, 32'h3);
        rd(acs_pkg::OFS_RES_LO, 32'hFF);
        rd(acs_pkg::OFS_STAT, 32'h0);
        wr(acs_pkg::OFS_CTRL1, 32'h0);
        for (int c = 0; c <= 18; c++) begin
            wr(acs_pkg::OFS_TRIG, 32'(c));
            TRIG_SOURCES <= ~18'((19'h1 << c) >> 1);
            repeat (40) @(posedge MCLK);
            pin(CONVERSION_DONE_FLAG, 1'b0);
            TRIG_SOURCES <= 18'h3FFFF;
            wait_flag(60);
            pin(CONVERSION_DONE_FLAG, c != 0);
            wr(acs_pkg::OFS_STAT, 32'h1);
            repeat (40) @(posedge MCLK);
            pin(CONVERSION_DONE_FLAG, 1'b0);
            TRIG_SOURCES <= 18'h0;
            repeat (4) @(posedge MCLK);
        end
        wr(acs_pkg::OFS_CTRL0, c0 | 32'h2);
        repeat (5) @(posedge MCLK);
        SLEEP <= 1'b1;
        repeat (5) @(posedge MCLK);
        pin(CONV_POWER, 1'b0);
        rd(acs_pkg::OFS_CTRL0, c0);
        rd(acs_pkg::OFS_STAT, 32'h4);
        SLEEP <= 1'b0;
        repeat (5) @(posedge MCLK);
        pin(CONV_POWER, 1'b1);
        wr(acs_pkg::OFS_CTRL1, 32'h70);
        for (int k = 0; k < 2; k++) begin
            wr(acs_pkg::OFS_INTEN, 32'(1 - k));
            wr(acs_pkg::OFS_CTRL0, c0 | 32'h2);
            SLEEP <= 1'b1;
            rd(acs_pkg::OFS_STAT, 32'h0);
            wait_flag(3000);
            repeat (3) @(posedge MCLK);
            pin(CONVERSION_DONE_FLAG, 1'b1);
            pin(wakes == 1, 1'b1);
            pin(CONV_POWER, k == 0);
            rd(acs_pkg::OFS_CTRL0, c0);
            SLEEP <= 1'b0;
            wr(acs_pkg::OFS_STAT, 32'h1);
        end
        wr(acs_pkg::OFS_CTRL0, c0 | 32'h2);
        repeat (10) @(posedge MCLK);
        do_reset();
        pin(CONV_POWER, 1'b0);
        rd(acs_pkg::OFS_CTRL0, 32'h0);
        rd(acs_pkg::OFS_CTRL1, 32'h0);
        repeat (2) @(posedge MCLK);
        report_and_stop();
    end
endmodule : test_acs_sequencer
`default_nettype wire

//--- verilog/acs_pkg.sv
// Shared constants for the conversion sequencer
`default_nettype none
package acs_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_RES_HI = 8'h08;
    localparam logic [7:0] OFS_RES_LO = 8'h0C;
    localparam logic [7:0] OFS_TRIG = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    localparam logic [7:0] OFS_INTEN = 8'h18;
    // Field positions
    localparam int CTRL0_EN_BIT = 0;
    localparam int CTRL0_GO_BIT = 1;
    localparam int CTRL0_CH_LSB = 2;
    localparam int CTRL1_FMT_BIT = 7;
    localparam int CTRL1_CS_LSB = 4;
    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_OFF_BIT = 2;
    // Reset values
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] TRIG_RST = 8'h00;
    // Result and code sizes
    localparam int RES_W = 10;
    localparam int CH_W = 6;
    localparam logic [2:0] CS_RC = 3'h7;
    localparam logic [7:0] TRIG_LAST = 8'h12;
    localparam int TRIG_N = 18;
    // Channel code boundaries
    localparam logic [5:0] CH_A_LAST = 6'h05;
    localparam logic [5:0] CH_B_FIRST = 6'h0C;
    localparam logic [5:0] CH_F_LAST = 6'h2F;
    localparam logic [5:0] CH_GND = 6'h3B;
    // Timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int INSTR_NS = 16;
    localparam int RC_TAD_NS = 1000;
    localparam int INSTR_CYC = (INSTR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RC_TAD_CYC = (RC_TAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Sequencer states, Gray along idle-delay-convert-off
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_CONV = 2'b11,
        ST_OFF = 2'b10
    } acs_state_e;

    // Unresolved bits copy the last resolved one
    function automatic logic [RES_W-1:0] fill_partial(input logic [RES_W-1:0] code,
                                                      input logic [3:0] idx);
        logic [RES_W-1:0] r;
        logic last;
        r = code;
        last = (idx == 4'(RES_W - 1)) ? 1'b0 : code[idx + 4'h1];
        for (int i = 0; i < RES_W; i++) begin
            if (4'(i) <= idx) begin
                r[i] = last;
            end
        end
        return r;
    endfunction : fill_partial

    function automatic logic ch_valid(input logic [5:0] ch);
        return (ch <= CH_A_LAST) || (ch >= CH_B_FIRST && ch <= CH_F_LAST) || (ch >= CH_GND);
    endfunction : ch_valid
endpackage : acs_pkg
`default_nettype wire

//--- verilog/acs_sar_engine.sv
// Successive approximation bit engine
`default_nettype none
module acs_sar_engine (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic start,
    input wire logic stop,
    input wire logic kill,
    input wire logic comp_in,
    output logic busy,
    output logic [acs_pkg::RES_W-1:0] trial,
    output logic [acs_pkg::RES_W-1:0] result,
    output logic done,
    output logic stopped
);
    logic [3:0] idx_ff;
    logic [acs_pkg::RES_W-1:0] code_ff;
    logic [acs_pkg::RES_W-1:0] result_ff;
    logic busy_ff;
    logic done_ff;
    logic stopped_ff;
    logic [acs_pkg::RES_W-1:0] resolved;

    always_comb begin
        resolved = code_ff;
        resolved[idx_ff] = comp_in;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_ff <= 1'b0;
            idx_ff <= 4'h0;
            code_ff <= '0;
            result_ff <= '0;
            done_ff <= 1'b0;
            stopped_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            stopped_ff <= 1'b0;
            if (kill) begin
                busy_ff <= 1'b0;
            end else if (start) begin
                busy_ff <= 1'b1;
                idx_ff <= 4'(acs_pkg::RES_W - 1);
                code_ff <= acs_pkg::RES_W'(1) << (acs_pkg::RES_W - 1);
            end else if (busy_ff && stop) begin
                result_ff <= acs_pkg::fill_partial(code_ff, idx_ff); // [R5] [R6]
                stopped_ff <= 1'b1;
                busy_ff <= 1'b0;
            end else if (busy_ff && tick) begin
                if (idx_ff == 4'h0) begin
                    result_ff <= resolved;
                    done_ff <= 1'b1;
                    busy_ff <= 1'b0;
                    code_ff <= resolved;
                end else begin
                    idx_ff <= idx_ff - 4'h1;
                    code_ff <= resolved | (acs_pkg::RES_W'(1) << (idx_ff - 4'h1));
                end
            end
        end
    end

    assign busy = busy_ff;
    assign trial = code_ff;
    assign result = result_ff;
    assign done = done_ff;
    assign stopped = stopped_ff;
endmodule : acs_sar_engine
`default_nettype wire

//--- verilog/acs_sequencer.sv
// Converter control sequencer with AHB-Lite register slave
// Summary of operation
// (R1) Converter stays off until software sets the enable bit.
// (R2) Writing 1 to start bit 1 of control 0 starts a conversion.
// (R3) Software enables the converter in an earlier write than the start.
// (R4) Completion clears start bit, sets done flag, loads result registers.
// (R5) Clearing start bit mid-conversion stops it and loads partial result.
// (R6) Unresolved bits of a partial result copy the last resolved bit.
// (R7) Reset returns all registers to defaults, converter off, conversion ended.
// (R8) RC conversion clock adds one instruction cycle before conversion starts.
// (R9) Sleep, RC clock, interrupt enabled: completion wakes the device.
// (R10) Sleep, RC clock, interrupt disabled: converter powers off after completion.
// (R11) Sleep with non-RC clock aborts conversion, powers off, enable stays set.
// (R12) Rising edge of selected trigger sets the start bit.
// (R13) Trigger code 0 disables; code 1 takes the routed trigger pin.
// (R14) Codes 2-11 select timers, captures, PWMs and oscillator in order.
// (R15) Codes 12-18 select comparators, pin change flag and logic cells.
// (R16) Software never programs reserved trigger codes above 0x12.
// (R17) Software keeps trigger spacing within converter timing needs.
// (R18) Channel field bits 7..2 route port A to F pins.
// (R19) Top channel codes select ground, temperature, DAC and references.
// (R20) Start bit reads 1 while converting, 0 otherwise.
// (R21) Trigger source is synchronised and its rising edge gives one pulse.
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`default_nettype none
module acs_sequencer (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [acs_pkg::TRIG_N-1:0] TRIG_SOURCES,
    input wire logic SLEEP,
    input wire logic COMP_IN,
    output logic [9:0] DAC_CODE,
    output logic [5:0] CHANNEL_SELECT,
    output logic CHANNEL_VALID,
    output logic CONV_POWER,
    output logic CONVERSION_DONE_FLAG,
    output logic WAKE_REQ
);
    logic rst_s1_ff;
    logic rst_n;
    logic rst_s2_ff;
    logic [7:0] ctrl0_ff;
    logic [7:0] ctrl1_ff;
    logic [7:0] trig_ff;
    logic inten_ff;
    logic flag_ff;
    logic [acs_pkg::RES_W-1:0] res_ff;
    logic [31:0] hrdata_ff;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [7:0] rd_addr;
    logic [31:0] rd_word;
    acs_pkg::acs_state_e state_ff;
    acs_pkg::acs_state_e nxt_state;
    logic [9:0] delay_ff;
    logic [9:0] tad_ff;
    logic wake_ff;
    logic [5:0] chan_ff;
    logic chan_ok_ff;
    logic power_ff;
    logic addr_phase;
    logic wr0;
    logic [7:0] wdata8;
    logic en_now;
    logic rc_sel;
    logic trig_pulse;
    logic start_req;
    logic eng_start;
    logic eng_stop;
    logic eng_kill;
    logic eng_busy;
    logic eng_done;
    logic eng_stopped;
    logic tick;
    logic [acs_pkg::RES_W-1:0] eng_result;
    logic [9:0] eng_trial;
    logic [9:0] tad_load;

    // Reset release through two flops
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    assign rst_n = rst_s2_ff;

    // Bus address phase and write decode
    assign addr_phase = HSEL & HTRANS[1] & HREADY;
    assign rd_addr = HADDR[7:0];
    assign wdata8 = HWDATA[7:0];
    assign wr0 = wr_pend_ff && (wr_addr_ff == acs_pkg::OFS_CTRL0);
    assign en_now = wr0 ? wdata8[acs_pkg::CTRL0_EN_BIT] : ctrl0_ff[acs_pkg::CTRL0_EN_BIT];
    assign rc_sel = ctrl1_ff[acs_pkg::CTRL1_CS_LSB +: 3] == acs_pkg::CS_RC;

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_phase & HWRITE;
            if (addr_phase) begin
                wr_addr_ff <= rd_addr;
            end
        end
    end

    // Read data is launched at the address phase edge: zero wait states
    always_comb begin
        rd_word = 32'h0000_0000;
        case (rd_addr)
            acs_pkg::OFS_CTRL0: rd_word[7:0] = ctrl0_ff; // [R20]
            acs_pkg::OFS_CTRL1: rd_word[7:0] = ctrl1_ff;
            acs_pkg::OFS_RES_HI: rd_word[7:0] = ctrl1_ff[acs_pkg::CTRL1_FMT_BIT] ?
                8'(res_ff[9:2]) : {6'h00, res_ff[9:8]};
            acs_pkg::OFS_RES_LO: rd_word[7:0] = ctrl1_ff[acs_pkg::CTRL1_FMT_BIT] ?
                {res_ff[1:0], 6'h00} : res_ff[7:0];
            acs_pkg::OFS_TRIG: rd_word[7:0] = trig_ff;
            acs_pkg::OFS_STAT: begin
                rd_word[acs_pkg::STAT_FLAG_BIT] = flag_ff;
                rd_word[acs_pkg::STAT_BUSY_BIT] = (state_ff == acs_pkg::ST_CONV);
                rd_word[acs_pkg::STAT_OFF_BIT] = (state_ff == acs_pkg::ST_OFF);
            end
            acs_pkg::OFS_INTEN: rd_word[0] = inten_ff;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_phase && !HWRITE) begin
            hrdata_ff <= rd_word;
        end
    end

    // Trigger selection and edge detection
    acs_trig_sel u_trig (
        .clk(MCLK),
        .rst_n(rst_n),
        .sel(trig_ff),
        .src(TRIG_SOURCES),
        .pulse(trig_pulse)
    );

    // A start only counts when the converter was already enabled before this write
    assign start_req = (state_ff == acs_pkg::ST_IDLE) &&
        ctrl0_ff[acs_pkg::CTRL0_EN_BIT] && en_now && // [R1] [R3]
        ((wr0 && wdata8[acs_pkg::CTRL0_GO_BIT]) || trig_pulse); // [R2] [R12]

    // Sequencer
    always_comb begin
        nxt_state = state_ff;
        eng_start = 1'b0;
        eng_stop = 1'b0;
        eng_kill = 1'b0;
        case (state_ff)
            acs_pkg::ST_IDLE: begin
                if (start_req) begin
                    nxt_state = rc_sel ? acs_pkg::ST_DELAY : acs_pkg::ST_CONV; // [R8]
                    eng_start = !rc_sel;
                end
            end
            acs_pkg::ST_DELAY: begin
                if (!en_now || (wr0 && !wdata8[acs_pkg::CTRL0_GO_BIT])) begin
                    nxt_state = acs_pkg::ST_IDLE;
                end else if (delay_ff == 10'h000) begin
                    nxt_state = acs_pkg::ST_CONV;
                    eng_start = 1'b1;
                end
            end
            acs_pkg::ST_CONV: begin
                if (!en_now) begin
                    nxt_state = acs_pkg::ST_IDLE;
                    eng_kill = 1'b1;
                end else if (SLEEP && !rc_sel) begin
                    nxt_state = acs_pkg::ST_OFF; // [R11]
                    eng_kill = 1'b1;
                end else if (eng_done) begin
                    nxt_state = (SLEEP && !inten_ff) ? acs_pkg::ST_OFF // [R10]
                        : acs_pkg::ST_IDLE;
                end else if (wr0 && !wdata8[acs_pkg::CTRL0_GO_BIT]) begin
                    nxt_state = acs_pkg::ST_IDLE;
                    eng_stop = 1'b1; // [R5]
                end
            end
            acs_pkg::ST_OFF: begin
                if (!SLEEP || !en_now) begin
                    nxt_state = acs_pkg::ST_IDLE;
                end
            end
            default: nxt_state = acs_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= acs_pkg::ST_IDLE; // [R7]
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Extra instruction before an RC-clocked conversion
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            delay_ff <= 10'h000;
        end else if (state_ff == acs_pkg::ST_IDLE) begin
            delay_ff <= 10'(acs_pkg::INSTR_CYC - 1); // [R8]
        end else if (delay_ff != 10'h000) begin
            delay_ff <= delay_ff - 10'h001;
        end
    end

    // Conversion clock enable: system clock divided, or the RC period
    assign tad_load = rc_sel ? 10'(acs_pkg::RC_TAD_CYC - 1)
        : 10'((2 << ctrl1_ff[acs_pkg::CTRL1_CS_LSB +: 3]) - 1);
    assign tick = (tad_ff == 10'h000);

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            tad_ff <= 10'h000;
        end else if (eng_start || tick) begin
            tad_ff <= tad_load;
        end else begin
            tad_ff <= tad_ff - 10'h001;
        end
    end

    acs_sar_engine u_sar (
        .clk(MCLK),
        .rst_n(rst_n),
        .tick(tick && !eng_start),
        .start(eng_start),
        .stop(eng_stop),
        .kill(eng_kill),
        .comp_in(COMP_IN),
        .busy(eng_busy),
        .trial(eng_trial),
        .result(eng_result),
        .done(eng_done),
        .stopped(eng_stopped)
    );

    // Control 0: start bit is set in the delay and convert states
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0_ff <= acs_pkg::CTRL0_RST; // [R7]
        end else begin
            if (wr0) begin
                ctrl0_ff[7:acs_pkg::CTRL0_CH_LSB] <= wdata8[7:acs_pkg::CTRL0_CH_LSB];
                ctrl0_ff[acs_pkg::CTRL0_EN_BIT] <= wdata8[acs_pkg::CTRL0_EN_BIT];
            end
            ctrl0_ff[acs_pkg::CTRL0_GO_BIT] <= (nxt_state == acs_pkg::ST_DELAY) ||
                (nxt_state == acs_pkg::ST_CONV); // [R4] [R20] [R12]
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1_ff <= acs_pkg::CTRL1_RST;
            trig_ff <= acs_pkg::TRIG_RST;
            inten_ff <= 1'b0;
        end else if (wr_pend_ff) begin
            if (wr_addr_ff == acs_pkg::OFS_CTRL1) begin
                ctrl1_ff <= wdata8 & 8'hF0;
            end
            if (wr_addr_ff == acs_pkg::OFS_TRIG) begin
                trig_ff <= wdata8;
            end
            if (wr_addr_ff == acs_pkg::OFS_INTEN) begin
                inten_ff <= wdata8[0];
            end
        end
    end

    // Results and done flag; hardware set wins over a write-one clear
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            res_ff <= '0;
        end else if (eng_done || eng_stopped) begin
            res_ff <= eng_result; // [R4] [R5]
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            flag_ff <= 1'b0;
        end else if (eng_done && state_ff == acs_pkg::ST_CONV) begin
            flag_ff <= 1'b1; // [R4]
        end else if (wr_pend_ff && wr_addr_ff == acs_pkg::OFS_STAT &&
                     wdata8[acs_pkg::STAT_FLAG_BIT]) begin
            flag_ff <= 1'b0;
        end
    end

    // Wake, channel routing and analog power
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            wake_ff <= 1'b0;
            chan_ff <= 6'h00;
            chan_ok_ff <= 1'b0;
            power_ff <= 1'b0;
        end else begin
            wake_ff <= eng_done && state_ff == acs_pkg::ST_CONV && SLEEP && rc_sel &&
                inten_ff; // [R9]
            chan_ff <= ctrl0_ff[7:acs_pkg::CTRL0_CH_LSB]; // [R18]
            chan_ok_ff <= acs_pkg::ch_valid(ctrl0_ff[7:acs_pkg::CTRL0_CH_LSB]); // [R18] [R19]
            power_ff <= en_now && nxt_state != acs_pkg::ST_OFF; // [R1] [R10] [R11]
        end
    end

    assign HRDATA = hrdata_ff;
    assign HREADYOUT = rst_n;
    assign HRESP = 1'b0;
    assign DAC_CODE = eng_trial;
    assign CHANNEL_SELECT = chan_ff;
    assign CHANNEL_VALID = chan_ok_ff;
    assign CONV_POWER = power_ff;
    assign CONVERSION_DONE_FLAG = flag_ff;
    assign WAKE_REQ = wake_ff;
endmodule : acs_sequencer
`default_nettype wire

//--- verilog/acs_trig_sel.sv
// Trigger source selection, synchroniser and rising edge detector
`default_nettype none
module acs_trig_sel (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] sel,
    input wire logic [acs_pkg::TRIG_N-1:0] src,
    output logic pulse
);
    logic chosen;
    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;

    // Codes 1..18 pick a source; 0 and reserved codes give no trigger
    always_comb begin
        chosen = 1'b0;
        if (sel != 8'h00 && sel <= acs_pkg::TRIG_LAST) begin
            chosen = src[5'(sel - 8'h01)]; // [R13] [R14] [R15]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            sync1_ff <= chosen; // [R21]
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    assign pulse = sync2_ff & ~prev_ff; // [R21] [R12]
endmodule : acs_trig_sel
`default_nettype wire
